// ---- tdc_consts.svh ----
`ifndef TDC_CONSTS_SVH
`define TDC_CONSTS_SVH

// command codes, upper byte of a frame
`define TDC_CMD_SELECT     8'h72
`define TDC_CMD_SOFT       8'h73
`define TDC_CMD_ENABLE     8'h74
`define TDC_CMD_CHAN_HI    4'h1

// reset values
`define TDC_SELECT_RESET   16'h0000
`define TDC_SOFT_RESET     16'h0000
`define TDC_ENABLE_RESET   16'h0000

// channel settings field positions within the data word
`define TDC_F_PER_LO       0
`define TDC_F_PER_HI       2
`define TDC_F_MODE         3
`define TDC_F_SRC_LO       4
`define TDC_F_SRC_HI       5
`define TDC_F_PH_LO        6
`define TDC_F_PH_HI        7

// accepted frame lengths in serial clock rising edges
`define TDC_FRAME_LONG     6'h20
`define TDC_FRAME_SHORT    6'h18

// synchroniser bit positions
`define TDC_P_SCK          0
`define TDC_P_SDI          1
`define TDC_P_CS           2
`define TDC_P_TG0          3
// idle pin levels: select high, everything else low
`define TDC_PIN_IDLE       6'h04

// sine position: one full period spans 64 steps, a quarter 16
`define TDC_QUARTER        6'h10
`define TDC_PER_MAX        3'h4

`endif

// ---- tdc_core.sv ----
`timescale 1ns/1ps
`include "tdc_consts.svh"

// Summary of operation
// - select command loads input select word
// - select bit routes writes A/B, resets zero
// - soft toggle command loads toggle bits
// - soft toggle changes at frame end
// - enable command loads enables, resets zero
// - toggle mode disable connects register A
// - dither disable finishes period then A
// - mode bit toggle or dither, reset 0
// - period code selects N 4..64
// - phase code sets start phase
// - odd phases silent first N/4 clocks
// - source code picks soft bit or pin
// - settings write hits addressed channel only
// - serial out lags input 32 edges
// - serial out released while select high
// - trailing frame bits ignored
// - toggle flips on both clock edges
// - dither rising edge steps sine sample
// - register A before enable set
module tdc_core #(
  parameter int NCH = 16
) (
  // clock, reset, enable
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           ce,
  // serial port pins
  input  wire logic                           sck,
  input  wire logic                           sdi,
  input  wire logic                           chip_select_load_n,
  output logic                                sdo,
  output logic                                sdo_oe,
  // toggle clock pins
  input  wire logic                           toggle_pin_0,
  input  wire logic                           toggle_pin_1,
  input  wire logic                           toggle_pin_2,
  // per channel results
  output logic          [NCH-1:0]             input_reg_select,
  output tdc_pkg::tdc_chan_out_t [NCH-1:0]    chan_out
);

  logic [5:0]  s1_reg;
  logic [5:0]  s2_reg;
  logic [5:0]  s3_reg;
  logic [5:0]  lvl_reg;
  logic [5:0]  lvl_next;
  logic [5:0]  pin_rise;
  logic [5:0]  pin_fall;
  logic [31:0] shift_reg;
  logic [5:0]  cnt_reg;
  logic        exec;
  logic [7:0]  cmd;
  logic [15:0] data;
  logic        exec_sel;
  logic        exec_soft;
  logic        exec_en;
  logic        exec_chan;
  logic [NCH-1:0] soft_reg;
  logic [NCH-1:0] en_reg;
  logic [NCH-1:0] src_rise;
  logic [NCH-1:0] src_fall;
  tdc_pkg::tdc_chan_cfg_t [NCH-1:0] cfg_reg;
  tdc_pkg::tdc_dither_t   [NCH-1:0] st_reg;
  logic [NCH-1:0][5:0] pos_reg;
  logic [NCH-1:0][5:0] warm_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // quarter sine magnitude in 1/32 units, index 0..16
  function automatic logic [5:0] quarter(input logic [4:0] k);
    logic [5:0] v;
    v = 6'h00;
    unique case (k)
      5'd0:  v = 6'd0;
      5'd1:  v = 6'd3;
      5'd2:  v = 6'd6;
      5'd3:  v = 6'd9;
      5'd4:  v = 6'd12;
      5'd5:  v = 6'd15;
      5'd6:  v = 6'd18;
      5'd7:  v = 6'd21;
      5'd8:  v = 6'd24;
      5'd9:  v = 6'd25;
      5'd10: v = 6'd27;
      5'd11: v = 6'd28;
      5'd12: v = 6'd30;
      5'd13: v = 6'd31;
      5'd14: v = 6'd31;
      default: v = 6'd32;
    endcase
    return v;
  endfunction

  // signed sample at a 64-step position
  function automatic logic signed [6:0] sine_at(input logic [5:0] m);
    logic [4:0] k;
    logic [6:0] mag;
    k = m[4] ? 5'd16 - {1'b0, m[3:0]} : {1'b0, m[3:0]};
    mag = {1'b0, quarter(k)};
    return m[5] ? -$signed(mag) : $signed(mag);
  endfunction

  // positions advanced per dither clock, 64/N
  function automatic logic [5:0] step_of(input logic [2:0] per);
    logic [2:0] p;
    p = (per > `TDC_PER_MAX) ? `TDC_PER_MAX : per;
    return `TDC_QUARTER >> p;
  endfunction

  // start position from phase code, quarter periods
  function automatic logic [5:0] start_of(input logic [1:0] ph);
    return {ph, 4'h0};
  endfunction

  // three-stage synchronisers for all pins
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= `TDC_PIN_IDLE; // stages match idle pins, no false edge after reset
      s2_reg <= `TDC_PIN_IDLE;
      s3_reg <= `TDC_PIN_IDLE;
      lvl_reg <= `TDC_PIN_IDLE;
    end else if (ce) begin
      s1_reg <= {toggle_pin_2, toggle_pin_1, toggle_pin_0, chip_select_load_n, sdi, sck};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  // level moves only when stages two and three agree
  assign lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
  assign pin_rise = lvl_next & ~lvl_reg;
  assign pin_fall = ~lvl_next & lvl_reg;

  // frame shifter and edge counter
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_reg <= 32'h0000_0000;
      cnt_reg <= 6'h00;
    end else if (ce) begin
      if (pin_fall[`TDC_P_CS]) begin
        cnt_reg <= 6'h00;
      end else if (pin_rise[`TDC_P_SCK] && !lvl_reg[`TDC_P_CS]) begin
        shift_reg <= {shift_reg[30:0], lvl_reg[`TDC_P_SDI]};
        if (cnt_reg != 6'h3f) begin
          cnt_reg <= cnt_reg + 6'h01;
        end
      end
    end
  end

  // decode at select rising edge, trailing bits unused
  assign exec = pin_rise[`TDC_P_CS] &&
                (cnt_reg == `TDC_FRAME_LONG || cnt_reg == `TDC_FRAME_SHORT);
  assign cmd  = (cnt_reg == `TDC_FRAME_SHORT) ? shift_reg[23:16] : shift_reg[31:24];
  assign data = (cnt_reg == `TDC_FRAME_SHORT) ? shift_reg[15:0] : shift_reg[23:8];
  assign exec_sel  = exec && cmd == `TDC_CMD_SELECT;
  assign exec_soft = exec && cmd == `TDC_CMD_SOFT;
  assign exec_en   = exec && cmd == `TDC_CMD_ENABLE;
  assign exec_chan = exec && cmd[7:4] == `TDC_CMD_CHAN_HI;

  // serial out on detected falling edge, enabled while selected
  always_ff @(posedge clk) begin
    if (rst) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (ce) begin
      if (pin_fall[`TDC_P_SCK]) begin
        sdo <= shift_reg[31];
      end
      sdo_oe <= ~lvl_next[`TDC_P_CS];
    end
  end

  sdo_lag_a: assert property (ce && pin_fall[`TDC_P_SCK] |=> sdo == $past(shift_reg[31]))
    else $error("serial out not taken from oldest shifted bit");
  sdo_float_a: assert property (ce && lvl_next[`TDC_P_CS] |=> !sdo_oe)
    else $error("serial out driven while select high");

  // input select word
  always_ff @(posedge clk) begin
    if (rst) begin
      input_reg_select <= `TDC_SELECT_RESET;
    end else if (ce && exec_sel) begin
      input_reg_select <= data;
    end
  end

  sel_write_a: assert property (ce && exec_sel |=> input_reg_select == $past(data))
    else $error("input select word not loaded");

  // software toggle bits, applied only at frame end
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_reg <= `TDC_SOFT_RESET;
    end else if (ce && exec_soft) begin
      soft_reg <= data;
    end
  end

  soft_frame_a: assert property (soft_reg != $past(soft_reg) |-> $past(exec_soft && ce))
    else $error("soft toggle changed outside frame end");

  // toggle and dither enables
  always_ff @(posedge clk) begin
    if (rst) begin
      en_reg <= `TDC_ENABLE_RESET;
    end else if (ce && exec_en) begin
      en_reg <= data;
    end
  end

  en_write_a: assert property (ce && exec_en |=> en_reg == $past(data))
    else $error("enable word not loaded");

  // channel settings, addressed channel only
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= '0;
    end else if (ce && exec_chan) begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (cmd[3:0] == 4'(ch)) begin
          cfg_reg[ch].mode   <= data[`TDC_F_MODE];
          cfg_reg[ch].period <= data[`TDC_F_PER_HI:`TDC_F_PER_LO];
          cfg_reg[ch].phase  <= data[`TDC_F_PH_HI:`TDC_F_PH_LO];
          cfg_reg[ch].src    <= tdc_pkg::tdc_src_t'(data[`TDC_F_SRC_HI:`TDC_F_SRC_LO]);
        end
      end
    end
  end

  chan_only_a: assert property (ce && exec_chan && cmd[3:0] != 4'h0 |=>
                                cfg_reg[0] == $past(cfg_reg[0]))
    else $error("settings of unaddressed channel changed");

  // edges of each channel's selected clock
  always_comb begin
    src_rise = '0;
    src_fall = '0;
    for (int ch = 0; ch < NCH; ch++) begin
      unique case (cfg_reg[ch].src)
        tdc_pkg::TDC_SRC_SOFT: begin
          src_rise[ch] = exec_soft && data[ch] && !soft_reg[ch];
          src_fall[ch] = exec_soft && !data[ch] && soft_reg[ch];
        end
        tdc_pkg::TDC_SRC_PIN0: begin
          src_rise[ch] = pin_rise[`TDC_P_TG0];
          src_fall[ch] = pin_fall[`TDC_P_TG0];
        end
        tdc_pkg::TDC_SRC_PIN1: begin
          src_rise[ch] = pin_rise[`TDC_P_TG0 + 1];
          src_fall[ch] = pin_fall[`TDC_P_TG0 + 1];
        end
        tdc_pkg::TDC_SRC_PIN2: begin
          src_rise[ch] = pin_rise[`TDC_P_TG0 + 2];
          src_fall[ch] = pin_fall[`TDC_P_TG0 + 2];
        end
      endcase
    end
  end

  // per channel toggle and dither engine, own index and period
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int ch = 0; ch < NCH; ch++) begin
        st_reg[ch] <= tdc_pkg::TDC_IDLE;
      end
      pos_reg <= '0;
      warm_reg <= '0;
      chan_out <= '0;
    end else if (ce) begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (!cfg_reg[ch].mode) begin
          st_reg[ch] <= tdc_pkg::TDC_IDLE;
          chan_out[ch].dither_on <= 1'b0;
          chan_out[ch].dither_val <= 7'sd0;
          if (!en_reg[ch]) begin
            chan_out[ch].use_b <= 1'b0;
          end else if (src_rise[ch] || src_fall[ch]) begin
            chan_out[ch].use_b <= ~chan_out[ch].use_b;
          end
        end else begin
          chan_out[ch].use_b <= 1'b0;
          unique case (st_reg[ch])
            tdc_pkg::TDC_IDLE: begin
              chan_out[ch].dither_on <= 1'b0;
              chan_out[ch].dither_val <= 7'sd0;
              if (en_reg[ch]) begin
                st_reg[ch] <= tdc_pkg::TDC_RUN;
                pos_reg[ch] <= start_of(cfg_reg[ch].phase);
                warm_reg[ch] <= 6'h00;
              end
            end
            tdc_pkg::TDC_RUN, tdc_pkg::TDC_DRAIN: begin
              if (!en_reg[ch]) begin
                st_reg[ch] <= tdc_pkg::TDC_DRAIN;
              end
              if (src_rise[ch]) begin
                if (st_reg[ch] == tdc_pkg::TDC_DRAIN &&
                    pos_reg[ch] == start_of(cfg_reg[ch].phase)) begin
                  st_reg[ch] <= tdc_pkg::TDC_IDLE;
                  chan_out[ch].dither_on <= 1'b0;
                  chan_out[ch].dither_val <= 7'sd0;
                end else begin
                  chan_out[ch].dither_on <= 1'b1;
                  if (cfg_reg[ch].phase[0] && warm_reg[ch] < `TDC_QUARTER) begin
                    chan_out[ch].dither_val <= 7'sd0;
                  end else begin
                    chan_out[ch].dither_val <= sine_at(pos_reg[ch]);
                  end
                  pos_reg[ch] <= pos_reg[ch] + step_of(cfg_reg[ch].period);
                  if (warm_reg[ch] < `TDC_QUARTER) begin
                    warm_reg[ch] <= warm_reg[ch] + step_of(cfg_reg[ch].period);
                  end
                end
              end
            end
            default: begin
              st_reg[ch] <= tdc_pkg::TDC_IDLE;
            end
          endcase
        end
      end
    end
  end

  toggle_off_a: assert property (ce && !cfg_reg[0].mode && !en_reg[0] |=> !chan_out[0].use_b)
    else $error("disabled toggle channel not on register A");
  toggle_flip_a: assert property (ce && !cfg_reg[0].mode && en_reg[0] && src_fall[0] |=>
                                  chan_out[0].use_b != $past(chan_out[0].use_b))
    else $error("toggle missed falling clock edge");

  // dither checks on every channel, whichever ones run dither
  for (genvar g = 0; g < NCH; g++) begin : g_dither
    sequence drain_end_s;
      ce && st_reg[g] == tdc_pkg::TDC_DRAIN && src_rise[g] && cfg_reg[g].mode &&
      pos_reg[g] == start_of(cfg_reg[g].phase);
    endsequence
    sequence back_to_a_s;
      st_reg[g] == tdc_pkg::TDC_IDLE && !chan_out[g].dither_on && !chan_out[g].use_b;
    endsequence

    drain_stop_a: assert property (drain_end_s |=> back_to_a_s)
      else $error("dither did not stop at period end");
    warm_quiet_a: assert property (ce && cfg_reg[g].mode && src_rise[g] &&
                                   st_reg[g] == tdc_pkg::TDC_RUN && cfg_reg[g].phase[0] &&
                                   warm_reg[g] < `TDC_QUARTER |=> chan_out[g].dither_val == 7'sd0)
      else $error("dither output during first quarter period");
    step_a: assert property (ce && cfg_reg[g].mode && en_reg[g] && src_rise[g] &&
                             st_reg[g] == tdc_pkg::TDC_RUN |=> pos_reg[g] ==
                             6'($past(pos_reg[g]) + step_of($past(cfg_reg[g].period))))
      else $error("sine index did not advance by one sample");
  end

endmodule

// ---- tdc_core_test.sv ----
`timescale 1ns/1ps
module tdc_core_test;
  logic                          clk = 1'b0;
  logic                          rst = 1'b1;
  logic [2:0]                    tp = 3'b000;
  logic                          sck;
  logic                          sdi;
  logic                          cs_n;
  logic                          sdo;
  logic                          sdo_oe;
  logic [15:0]                   sel;
  tdc_pkg::tdc_chan_out_t [15:0] chan_out;
  int                            fail_count = 0;
  int                            tests_run = 0;
  int                            cyc = 0;
  logic [31:0]                   seed = 32'h0000_0043;
  logic [159:0]                  notes[$];
  logic [159:0]                  last;
  logic [159:0]                  prev;
  logic                          armed = 1'b0;
  logic [15:0]                   m_sel = 16'h0000;
  logic [8:0]                    m_ch[16];

  // clock
  always #2 clk = ~clk;

  tdc_core #(.NCH(16)) dut_u (
    .clk(clk), .rst(rst), .ce(1'b1), .sck(sck), .sdi(sdi), .chip_select_load_n(cs_n),
    .sdo(sdo), .sdo_oe(sdo_oe), .toggle_pin_0(tp[0]), .toggle_pin_1(tp[1]),
    .toggle_pin_2(tp[2]), .input_reg_select(sel), .chan_out(chan_out));
  tdc_host host_u (.clk(clk), .sck(sck), .sdi(sdi), .chip_select_load_n(cs_n),
    .sdo(sdo), .sdo_oe(sdo_oe));

  // xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // outputs folded so an idle sample value is not compared
  function automatic logic [159:0] norm();
    logic [159:0] s;
    s = {sel, 144'h0};
    for (int c = 0; c < 16; c++) begin
      s[c*9 +: 9] = {chan_out[c].use_b, chan_out[c].dither_on,
                     chan_out[c].dither_on ? chan_out[c].dither_val : 7'sh00};
    end
    return s;
  endfunction

  function automatic logic [159:0] model();
    logic [159:0] s;
    s = {m_sel, 144'h0};
    for (int c = 0; c < 16; c++) begin
      s[c*9 +: 9] = m_ch[c];
    end
    return s;
  endfunction

  task automatic cmp_state(input logic [159:0] got, input logic [159:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t output state %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t serial value %h expected %h", $time, got, exp);
    end
  endtask

  // queue the model state when it differs from the last note
  task automatic note();
    logic [159:0] s;
    s = model();
    if (s !== last) begin
      notes.push_back(s);
      last = s;
    end
  endtask

  task automatic cmd(input logic [7:0] c, input logic [15:0] w, input int n);
    logic [63:0] d;
    logic [63:0] q;
    logic [31:0] r;
    r = xs();
    d = {32'h0, c, w, r[7:0]} >> (32 - n); // random trailing byte
    host_u.xfer(n, d, q);
  endtask

  task automatic pin(input int i, input logic v);
    @(posedge clk) tp[i] <= v;
    repeat (16) @(posedge clk);
  endtask

  task automatic close_out();
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watcher: each output change consumes the oldest note
  always @(negedge clk) begin
    if (armed && norm() !== prev) begin
      prev = norm();
      if (notes.size() == 0) begin
        cmp_state(prev, 'x);
      end else begin
        cmp_state(prev, notes.pop_front());
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      close_out();
    end
  end

  // main sequence
  initial begin
    logic [31:0]       r;
    logic [31:0]       r2;
    logic [63:0]       d;
    logic [63:0]       q;
    logic signed [6:0] w2[5];
    logic signed [6:0] w3[5];
    logic [23:0]       setup[5];
    int                len[3];
    w2 = '{7'sh00, 7'sh20, 7'sh00, -7'sh20, 7'sh00};
    w3 = '{7'sh00, -7'sh20, 7'sh00, 7'sh20, 7'sh00};
    setup = '{24'h10_0010, 24'h11_0000, 24'h12_0028, 24'h13_00a8, 24'h14_0079};
    len = '{32, 24, 20};
    foreach (m_ch[i]) m_ch[i] = 9'h000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    cmp_state(norm(), model());
    cmp_word({63'h0, sdo_oe}, 64'h0);
    last = model();
    prev = norm();
    armed = 1'b1;
    // select word by long and short frame, then a refused length
    foreach (len[k]) begin
      r = xs();
      if (len[k] != 20) m_sel = r[15:0];
      note();
      cmd(8'h72, r[15:0], len[k]);
    end
    // two chained words: the first comes back out on sdo
    r = xs();
    r2 = xs();
    d = {8'hf0, r[23:0], 8'hf0, r2[23:0]};
    host_u.xfer(64, d, q);
    cmp_word({32'h0, q[31:0]}, {32'h0, d[63:32]});
    cmp_word({63'h0, sdo_oe}, 64'h0);
    // channel settings, only legal period codes
    foreach (setup[k]) cmd(setup[k][23:16], setup[k][15:0], 32);
    pin(0, 1'b1);
    pin(0, 1'b0);
    cmd(8'h74, 16'h001f, 32);
    // toggle follows both pin edges
    for (int k = 0; k < 3; k++) begin
      m_ch[0] = {~k[0], 8'h00};
      note();
      pin(0, ~k[0]);
    end
    // soft toggle acts when the frame executes
    m_ch[1] = 9'h100;
    note();
    cmd(8'h73, 16'h0002, 32);
    m_ch[1] = 9'h000;
    note();
    cmd(8'h73, 16'h0000, 32);
    // two dither channels on one clock, opposite phase, disabled mid-period and run on to period end
    for (int k = 0; k < 5; k++) begin
      m_ch[2] = {1'b0, k < 4, w2[k]};
      m_ch[3] = {1'b0, k < 4, w3[k]};
      note();
      pin(1, 1'b1);
      pin(1, 1'b0);
      if (k == 1) cmd(8'h74, 16'h0013, 32);
    end
    // quarter-phase start stays silent, then mode change aborts
    m_ch[4] = 9'h080;
    note();
    for (int k = 0; k < 2; k++) begin
      pin(2, 1'b1);
      pin(2, 1'b0);
    end
    m_ch[4] = 9'h000;
    note();
    cmd(8'h14, 16'h0071, 32);
    // toggle disable returns to A at once
    m_ch[0] = 9'h000;
    note();
    cmd(8'h74, 16'h0000, 32);
    repeat (20) @(posedge clk);
    cmp_word(64'(notes.size()), 64'h0);
    close_out();
  end
endmodule

// ---- tdc_host.sv ----
`timescale 1ns/1ps
// host serial master: link clock of 64 ns, held low between frames
module tdc_host (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      sck,
  output logic      sdi,
  output logic      chip_select_load_n,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  // idle levels at time zero
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    chip_select_load_n = 1'b1;
  end

  // one frame of n bits, msb first; q gathers sdo at every sck rise
  task automatic xfer(input int n, input logic [63:0] d, output logic [63:0] q);
    q = '0;
    @(posedge clk) chip_select_load_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sdi <= d[i];
      repeat (8) @(posedge clk);
      sck <= 1'b1;
      q = {q[62:0], sdo_oe ? sdo : 1'b1}; // released output reads as its pull-up
      repeat (8) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    chip_select_load_n <= 1'b1;
    sdi <= ~sdi; // released line shows no stale bit
    repeat (16) @(posedge clk);
  endtask
endmodule

// ---- tdc_pkg.sv ----
package tdc_pkg;

  typedef enum logic [1:0] {
    TDC_SRC_SOFT,
    TDC_SRC_PIN0,
    TDC_SRC_PIN1,
    TDC_SRC_PIN2
  } tdc_src_t;

  typedef enum logic [1:0] {
    TDC_IDLE,
    TDC_RUN,
    TDC_DRAIN
  } tdc_dither_t;

  typedef struct packed {
    logic [1:0] phase;
    tdc_src_t   src;
    logic       mode;
    logic [2:0] period;
  } tdc_chan_cfg_t;

  typedef struct packed {
    logic              use_b;
    logic              dither_on;
    logic signed [6:0] dither_val;
  } tdc_chan_out_t;

endpackage
